// ==== hdl/csd_pkg.sv ====
// ----------------------------------------------------------------------
// csd_pkg: shared constants for the line/supply match debounce and irq block
// ----------------------------------------------------------------------
// assumes one 40 MHz clock; offsets are 12-bit register addresses
package csd_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_LINE1_CHG_STS  = 12'h0806;
  localparam logic [11:0] OFS_LINE2_CHG_STS  = 12'h0807;
  localparam logic [11:0] OFS_SUPPLY_CHG_STS = 12'h0809;
  localparam logic [11:0] OFS_LINE1_MATCH_EN = 12'h0812;
  localparam logic [11:0] OFS_LINE2_MATCH_EN = 12'h0813;
  localparam logic [11:0] OFS_SUPPLY_MATCH_EN = 12'h0814;
  localparam logic [11:0] OFS_POWER_IRQ_EN   = 12'h0815;
  localparam logic [11:0] OFS_DEBUG_IRQ_EN   = 12'h0816;
  localparam logic [11:0] OFS_MATCH_DEBOUNCE_PERIOD      = 12'h0817;
  localparam logic [11:0] OFS_DELIVERY_DEB   = 12'h0818;
  localparam logic [11:0] OFS_OC_BD_DEB      = 12'h0819;
  localparam logic [11:0] OFS_LINE1_INCL     = 12'h081a;
  localparam logic [11:0] OFS_LINE2_INCL     = 12'h081b;
  localparam logic [11:0] OFS_SUPPLY_INCL    = 12'h081c;

  // ------------------------------------------------------------------
  // field layouts and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] SUPPLY_BITS_MASK   = 8'h3d;   // bits 5:2 and 0
  localparam logic [7:0] DEBUG_BITS_MASK    = 8'h07;   // bits 2:0
  localparam logic [7:0] RST_ENABLE         = 8'h00;
  localparam logic [7:0] RST_MATCH_DEBOUNCE_PERIOD      = 8'h02;
  localparam logic [7:0] RST_DELIVERY_DEB   = 8'h0a;
  localparam logic [7:0] RST_OC_BD_DEB      = 8'h02;
  localparam logic [7:0] RST_INCLUDE        = 8'h00;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int FINE_STEP_NS    = 100_000;     // 100 us step
  localparam int MS_STEP_NS      = 1_000_000;   // 1 ms step
  localparam int FINE_STEP_CYCLES = FINE_STEP_NS / CLK_PERIOD_NS;
  localparam int MS_STEP_CYCLES  = MS_STEP_NS / CLK_PERIOD_NS;

endpackage

// ==== hdl/csd_match_debouncer.sv ====
// ----------------------------------------------------------------------
// csd_match_debouncer: shared match debouncer with per-bit include mask
// ----------------------------------------------------------------------
// assumes tick_in is a one-cycle pulse per debounce step
module csd_match_debouncer
  import csd_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         mclk_in,     // system clock
  input  wire logic         resetn_in,   // sync reset, low
  input  wire logic [W-1:0] raw_in,      // raw comparator matches
  input  wire logic [W-1:0] incl_in,     // applied include mask
  input  wire logic         tick_in,     // step pulse
  input  wire logic [7:0]   period_in,   // steps to settle
  output logic      [W-1:0] match_out,   // debounced match
  output logic      [W-1:0] change_out   // one-cycle change pulses
);

  if (W < 1) begin : g_chk
    $error("csd_match_debouncer: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] prev_incl;
    logic [W-1:0] cand;
    logic [7:0]   cnt;
    logic [W-1:0] match;
    logic [W-1:0] change;
  } csd_deb_t;

  csd_deb_t st;
  csd_deb_t next_st;
  logic [W-1:0] masked;
  logic [W-1:0] old_masked;
  logic         restart;
  logic         settled;

  // ------------------------------------------------------------------
  // one counter for the whole vector: any included change restarts it
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    masked     = raw_in & incl_in;
    old_masked = raw_in & st.prev_incl;
    // only bits kept in the mask are held against the candidate, so a
    // dropped bit never looks like a change; newly set bits restart only
    // when they alter the vector
    restart    = (|((masked ^ st.cand) & incl_in & st.prev_incl)) ||
                 ((|(incl_in & ~st.prev_incl)) && (masked != old_masked));
    // dropped include bits fall through without restarting
    settled    = !restart && (st.cnt >= period_in);
    next_st.cand = masked;
    if (restart)
    begin
      next_st.cnt  = 8'h00;
    end
    else if (tick_in && (st.cnt < period_in))
    begin
      next_st.cnt = st.cnt + 8'h01;
    end
    // excluded bits track raw at once; included ones wait to settle
    next_st.match  = (~incl_in & raw_in) |
                     (incl_in & (settled ? st.cand : st.match));
    next_st.change = next_st.match ^ st.match;
    next_st.prev_incl = incl_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign match_out  = st.match;
  assign change_out = st.change;

endmodule

// ==== hdl/csd_level_filter.sv ====
// ----------------------------------------------------------------------
// csd_level_filter: per-bit level debounce over a common step period
// ----------------------------------------------------------------------
// assumes tick_in is a one-cycle pulse; output follows input after period
module csd_level_filter
  import csd_pkg::*;
#(
  parameter int W = 3
)
(
  input  wire logic         mclk_in,    // system clock
  input  wire logic         resetn_in,  // sync reset, low
  input  wire logic [W-1:0] level_in,   // raw levels
  input  wire logic         tick_in,    // step pulse
  input  wire logic [7:0]   period_in,  // steps of stability needed
  output logic      [W-1:0] level_out   // filtered levels
);

  if (W < 1) begin : g_chk
    $error("csd_level_filter: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0][7:0] cnt;
    logic [W-1:0]      lvl;
  } csd_flt_t;

  csd_flt_t st;
  csd_flt_t next_st;

  // ------------------------------------------------------------------
  // each bit counts steps while it disagrees; a bounce restarts it
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    for (int i = 0; i < W; i++)
    begin
      if (level_in[i] == st.lvl[i])
        next_st.cnt[i] = 8'h00;
      else if (st.cnt[i] >= period_in)
      begin
        next_st.lvl[i] = level_in[i];
        next_st.cnt[i] = 8'h00;
      end
      else if (tick_in)
        next_st.cnt[i] = st.cnt[i] + 8'h01;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign level_out = st.lvl;

endmodule

// ==== hdl/csd_irq_debounce.sv ====
// ----------------------------------------------------------------------
// csd_irq_debounce: match/power/debug irq enables and debounce control
// ----------------------------------------------------------------------
// assumes a register port decoded from the serial host link, one clock,
// and comparator/status sources from neighbouring blocks
//
// Functional notes
// - line match-enable bits let change status raise line irq; reset zero
// - supply enable bits 5:2,0 writable, bit 1 read-only, 7:6 reserved
// - eight power irq enables, reset zero, zero blocks that source
// - three debug irq enables in low bits, zero blocks that source
// - match debounce waits programmed steps, reset two, 100 us when selected
// - realised match debounce may be up to one step short, never long
// - delivery debounce counts eight-bit period in 1 ms, reset ten
// - overcurrent and back-drive debounce eight-bit 1 ms period, reset two
// - line include bits put thresholds into line debouncer, reset zero
// - supply include bits 5:2 thresholds 3:0, bit 0 safe-zero level
// - newly set include bits restart debouncer if masked vector changes
// - clearing include bits never restarts the debouncer by itself
// - one line debouncer for both lines; change on either restarts it
// - line include changes take effect only at end of scan cycle
// - excluded threshold updates match at once, sets status, may interrupt
// - change status bits clear one by one on write of one
module csd_irq_debounce
  import csd_pkg::*;
#(
  parameter int MS_CYCLES     = MS_STEP_CYCLES,  // cycles per 1 ms step
  parameter int COARSE_CYCLES = MS_STEP_CYCLES   // step when fine select clear
)
(
  input  wire logic        mclk_in,                 // 40 MHz clock
  input  wire logic        resetn_in,               // sync reset, low
  input  wire logic [11:0] reg_addr_in,             // register address
  input  wire logic        reg_wr_in,               // write strobe
  input  wire logic [7:0]  reg_wdata_in,            // write data
  output logic      [7:0]  reg_rdata_out,           // read data, next cycle
  input  wire logic [7:0]  line1_raw_in,            // line 1 comparator hits
  input  wire logic [7:0]  line2_raw_in,            // line 2 comparator hits
  input  wire logic [7:0]  supply_raw_in,           // supply comparator hits
  input  wire logic        scan_end_in,             // end of line scan pulse
  input  wire logic        debounce_step_select_in, // 1: 100 us steps
  input  wire logic [7:0]  power_status_in,         // power irq status
  input  wire logic [2:0]  debug_status_in,         // debug irq status
  input  wire logic        delivery_level_in,       // raw delivery condition
  input  wire logic        overcurrent_in,          // raw overcurrent
  input  wire logic [1:0]  backdrive_in,            // raw back-drive, per line
  output logic      [7:0]  line1_match_result_out,  // debounced line 1
  output logic      [7:0]  line2_match_result_out,  // debounced line 2
  output logic      [7:0]  supply_match_result_out, // debounced supply
  output logic             line1_match_change_irq_out, // line 1 irq
  output logic             line2_match_change_irq_out, // line 2 irq
  output logic             line_irq_out,            // either line irq
  output logic             supply_irq_out,          // supply irq
  output logic             power_irq_out,           // power irq
  output logic             debug_irq_out,           // debug irq
  output logic             delivery_debounced_out,  // filtered delivery
  output logic             overcurrent_debounced_out, // filtered overcurrent
  output logic      [1:0]  backdrive_debounced_out  // filtered back-drive
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if ((MS_CYCLES < 1) || (MS_CYCLES > 65535)) begin : g_chk_ms
    $error("csd_irq_debounce: MS_CYCLES out of range");
  end
  if ((COARSE_CYCLES < 1) || (COARSE_CYCLES > 65535)) begin : g_chk_coarse
    $error("csd_irq_debounce: COARSE_CYCLES out of range");
  end

  localparam logic [15:0] MS_LAST     = 16'(MS_CYCLES - 1);
  localparam logic [15:0] COARSE_LAST = 16'(COARSE_CYCLES - 1);
  localparam logic [15:0] FINE_LAST   = 16'(FINE_STEP_CYCLES - 1);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  line1_en;
    logic [7:0]  line2_en;
    logic [7:0]  supply_en;
    logic [7:0]  power_en;
    logic [7:0]  debug_en;
    logic [7:0]  match_per;
    logic [7:0]  delivery_per;
    logic [7:0]  oc_bd_per;
    logic [7:0]  line1_incl;    // as written by software
    logic [7:0]  line2_incl;
    logic [15:0] line_incl_act; // as seen by the line debouncer
    logic [7:0]  supply_incl;
    logic [7:0]  line1_sts;
    logic [7:0]  line2_sts;
    logic [7:0]  supply_sts;
    logic [15:0] ms_cnt;
    logic [15:0] fine_cnt;
    logic [15:0] coarse_cnt;
    logic        ms_tick;
    logic        fine_tick;
    logic        coarse_tick;
    logic        line1_irq;
    logic        line2_irq;
    logic        line_irq;
    logic        supply_irq;
    logic        power_irq;
    logic        debug_irq;
    logic [7:0]  rdata;
  } csd_state_t;

  csd_state_t st;
  csd_state_t next_st;

  logic [15:0] line_match;
  logic [15:0] line_change;
  logic [5:0]  supply_match;
  logic [5:0]  supply_change;
  logic        match_tick;
  logic        wr_line1_sts;
  logic        wr_line2_sts;
  logic        wr_supply_sts;
  logic [2:0]  oc_bd_filtered;

  // step selection for the match debouncer; phase of the free-running
  // step counter makes the realised wait up to one step short, never long
  assign match_tick = debounce_step_select_in ? st.fine_tick : st.coarse_tick;

  // ------------------------------------------------------------------
  // debouncers
  // ------------------------------------------------------------------
  // both lines share one debouncer so a change on either restarts it
  csd_match_debouncer #(
    .W (16)
  ) u_line_deb (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .raw_in     ({line2_raw_in, line1_raw_in}),
    .incl_in    (st.line_incl_act),
    .tick_in    (match_tick),
    .period_in  (st.match_per),
    .match_out  (line_match),
    .change_out (line_change)
  );

  // supply vector keeps bits 5:2 and 0; bit 1 is never debounced
  csd_match_debouncer #(
    .W (6)
  ) u_supply_deb (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .raw_in     (supply_raw_in[5:0] & SUPPLY_BITS_MASK[5:0]),
    .incl_in    (st.supply_incl[5:0]),
    .tick_in    (match_tick),
    .period_in  (st.match_per),
    .match_out  (supply_match),
    .change_out (supply_change)
  );

  // power-delivery interval in 1 ms steps
  csd_level_filter #(
    .W (1)
  ) u_delivery_flt (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .level_in  (delivery_level_in),
    .tick_in   (st.ms_tick),
    .period_in (st.delivery_per),
    .level_out (delivery_debounced_out)
  );

  // overcurrent and both back-drive detectors share one period
  csd_level_filter #(
    .W (3)
  ) u_oc_bd_flt (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .level_in  ({backdrive_in, overcurrent_in}),
    .tick_in   (st.ms_tick),
    .period_in (st.oc_bd_per),
    .level_out (oc_bd_filtered)
  );

  assign overcurrent_debounced_out = oc_bd_filtered[0];
  assign backdrive_debounced_out   = oc_bd_filtered[2:1];

  // ------------------------------------------------------------------
  // write decode for change status
  // ------------------------------------------------------------------
  assign wr_line1_sts  = reg_wr_in && (reg_addr_in == OFS_LINE1_CHG_STS);
  assign wr_line2_sts  = reg_wr_in && (reg_addr_in == OFS_LINE2_CHG_STS);
  assign wr_supply_sts = reg_wr_in && (reg_addr_in == OFS_SUPPLY_CHG_STS);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_st = st;

    // step generators, free running
    next_st.ms_tick     = (st.ms_cnt == MS_LAST);
    next_st.ms_cnt      = next_st.ms_tick ? 16'h0000 : st.ms_cnt + 16'h0001;
    next_st.fine_tick   = (st.fine_cnt == FINE_LAST);
    next_st.fine_cnt    = next_st.fine_tick ? 16'h0000 : st.fine_cnt + 16'h0001;
    next_st.coarse_tick = (st.coarse_cnt == COARSE_LAST);
    next_st.coarse_cnt  = next_st.coarse_tick ? 16'h0000 : st.coarse_cnt + 16'h0001;

    // register writes
    if (reg_wr_in)
    begin
      case (reg_addr_in)
        OFS_LINE1_MATCH_EN:  next_st.line1_en     = reg_wdata_in;
        OFS_LINE2_MATCH_EN:  next_st.line2_en     = reg_wdata_in;
        OFS_SUPPLY_MATCH_EN: next_st.supply_en    = reg_wdata_in & SUPPLY_BITS_MASK;
        OFS_POWER_IRQ_EN:    next_st.power_en     = reg_wdata_in;
        OFS_DEBUG_IRQ_EN:    next_st.debug_en     = reg_wdata_in & DEBUG_BITS_MASK;
        OFS_MATCH_DEBOUNCE_PERIOD:       next_st.match_per    = reg_wdata_in;
        OFS_DELIVERY_DEB:    next_st.delivery_per = reg_wdata_in;
        OFS_OC_BD_DEB:       next_st.oc_bd_per    = reg_wdata_in;
        OFS_LINE1_INCL:      next_st.line1_incl   = reg_wdata_in;
        OFS_LINE2_INCL:      next_st.line2_incl   = reg_wdata_in;
        OFS_SUPPLY_INCL:     next_st.supply_incl  = reg_wdata_in & SUPPLY_BITS_MASK;
        default:             next_st.rdata        = st.rdata;
      endcase
    end

    // line include mask moves to the debouncer only between scans
    if (scan_end_in)
      next_st.line_incl_act = {st.line2_incl, st.line1_incl};

    // sticky change status; a new change beats a clearing write
    next_st.line1_sts  = (st.line1_sts & ~(wr_line1_sts ? reg_wdata_in : 8'h00))
                         | line_change[7:0];
    next_st.line2_sts  = (st.line2_sts & ~(wr_line2_sts ? reg_wdata_in : 8'h00))
                         | line_change[15:8];
    next_st.supply_sts = (st.supply_sts & ~(wr_supply_sts ? reg_wdata_in : 8'h00))
                         | ({2'b00, supply_change} & SUPPLY_BITS_MASK);

    // level interrupts from status AND enable
    next_st.line1_irq  = |(st.line1_sts & st.line1_en);
    next_st.line2_irq  = |(st.line2_sts & st.line2_en);
    next_st.line_irq   = next_st.line1_irq | next_st.line2_irq;
    next_st.supply_irq = |(st.supply_sts & st.supply_en);
    next_st.power_irq  = |(power_status_in & st.power_en);
    next_st.debug_irq  = |(debug_status_in & st.debug_en[2:0]);

    // registered read; unmapped addresses return zero
    case (reg_addr_in)
      OFS_LINE1_CHG_STS:   next_st.rdata = st.line1_sts;
      OFS_LINE2_CHG_STS:   next_st.rdata = st.line2_sts;
      OFS_SUPPLY_CHG_STS:  next_st.rdata = st.supply_sts;
      OFS_LINE1_MATCH_EN:  next_st.rdata = st.line1_en;
      OFS_LINE2_MATCH_EN:  next_st.rdata = st.line2_en;
      OFS_SUPPLY_MATCH_EN: next_st.rdata = st.supply_en;
      OFS_POWER_IRQ_EN:    next_st.rdata = st.power_en;
      OFS_DEBUG_IRQ_EN:    next_st.rdata = st.debug_en;
      OFS_MATCH_DEBOUNCE_PERIOD:       next_st.rdata = st.match_per;
      OFS_DELIVERY_DEB:    next_st.rdata = st.delivery_per;
      OFS_OC_BD_DEB:       next_st.rdata = st.oc_bd_per;
      OFS_LINE1_INCL:      next_st.rdata = st.line1_incl;
      OFS_LINE2_INCL:      next_st.rdata = st.line2_incl;
      OFS_SUPPLY_INCL:     next_st.rdata = st.supply_incl;
      default:             next_st.rdata = 8'h00;
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
    begin
      st              <= '0;
      st.line1_en     <= RST_ENABLE;
      st.line2_en     <= RST_ENABLE;
      st.supply_en    <= RST_ENABLE;
      st.power_en     <= RST_ENABLE;
      st.debug_en     <= RST_ENABLE;
      st.match_per    <= RST_MATCH_DEBOUNCE_PERIOD;
      st.delivery_per <= RST_DELIVERY_DEB;
      st.oc_bd_per    <= RST_OC_BD_DEB;
      st.line1_incl   <= RST_INCLUDE;
      st.line2_incl   <= RST_INCLUDE;
      st.supply_incl  <= RST_INCLUDE;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  assign reg_rdata_out              = st.rdata;
  assign line1_match_result_out     = line_match[7:0];
  assign line2_match_result_out     = line_match[15:8];
  assign supply_match_result_out    = {2'b00, supply_match} & SUPPLY_BITS_MASK;
  assign line1_match_change_irq_out = st.line1_irq;
  assign line2_match_change_irq_out = st.line2_irq;
  assign line_irq_out               = st.line_irq;
  assign supply_irq_out             = st.supply_irq;
  assign power_irq_out              = st.power_irq;
  assign debug_irq_out              = st.debug_irq;

endmodule

// ==== verif/csd_irq_monitor.sv ====
// checker for the irq enable and debounce block, bound to its top
// assumes registers are written only through the parallel port it sees
module csd_irq_monitor
(
  input wire logic        mclk_in,                 // clock
  input wire logic        resetn_in,               // sync reset, low
  input wire logic [11:0] reg_addr_in,             // address
  input wire logic        reg_wr_in,               // write strobe
  input wire logic [7:0]  reg_wdata_in,            // write data
  input wire logic [7:0]  reg_rdata_out,           // read data
  input wire logic [7:0]  line1_raw_in,            // line 1 raw
  input wire logic [7:0]  supply_raw_in,           // supply raw
  input wire logic        scan_end_in,             // scan end pulse
  input wire logic [7:0]  power_status_in,         // power status
  input wire logic [2:0]  debug_status_in,         // debug status
  input wire logic [7:0]  line1_match_result_out,  // line 1 result
  input wire logic [7:0]  supply_match_result_out, // supply result
  input wire logic        line_irq_out,            // line irq
  input wire logic        supply_irq_out,          // supply irq
  input wire logic        power_irq_out,           // power irq
  input wire logic        debug_irq_out            // debug irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  logic [7:0] pen, iw, ia, si;
  logic [2:0] den;
  // shadow copies; line include lands only at scan end, as in the block
  always_ff @(posedge mclk_in)
    if (!resetn_in)
      {pen, den, iw, ia, si} <= '0;
    else
    begin
      if (scan_end_in)
        ia <= iw;
      if (reg_wr_in)
        case (reg_addr_in)
          12'h0815: pen <= reg_wdata_in;
          12'h0816: den <= reg_wdata_in[2:0];
          12'h081a: iw <= reg_wdata_in;
          12'h081c: si <= reg_wdata_in;
          default: ;
        endcase
    end
  // ---
  // assertions
  // ---
  a_power_irq_value: assert property (
    power_irq_out == |($past(power_status_in) & $past(pen))) else $error("power irq wrong");
  a_debug_irq_value: assert property (
    debug_irq_out == |($past(debug_status_in) & $past(den))) else $error("debug irq wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !resetn_in |=>
    reg_rdata_out == 8'h00 && !(line_irq_out || supply_irq_out)) else $error("reset");
  a_supply_spare: assert property (
    (supply_match_result_out & 8'hc2) == 8'h00) else $error("supply spare bits set");
  a_supply_rd_mask: assert property (reg_addr_in == 12'h0814 |=>
    (reg_rdata_out & 8'hc2) == 8'h00) else $error("supply enable spare bits read");
  a_debug_rd_mask: assert property (reg_addr_in == 12'h0816 |=>
    reg_rdata_out[7:3] == 5'h00) else $error("debug enable spare bits read");
  a_line_excl_follow: assert property ($past(resetn_in) |->
    ((line1_match_result_out ^ $past(line1_raw_in)) & ~(ia | $past(ia) | $past(ia, 2)))
    == 8'h00) else $error("excluded line bit not following raw");
  a_supply_excl_follow: assert property ($past(resetn_in) |->
    ((supply_match_result_out ^ $past(supply_raw_in)) & ~(si | $past(si)) & 8'h3d)
    == 8'h00) else $error("excluded supply bit not following raw");
  c_power_irq: cover property ($rose(power_irq_out));
  c_line_match: cover property ($fell(line1_match_result_out[0]));
  c_scan_end: cover property (scan_end_in && ia != iw);
endmodule

bind csd_irq_debounce csd_irq_monitor mon (.mclk_in, .resetn_in, .reg_addr_in, .reg_wr_in,
  .reg_wdata_in, .reg_rdata_out, .line1_raw_in, .supply_raw_in, .scan_end_in,
  .power_status_in, .debug_status_in, .line1_match_result_out, .supply_match_result_out,
  .line_irq_out, .supply_irq_out, .power_irq_out, .debug_irq_out);

// ==== verif/csd_host_model.sv ====
// host software model: register writes and reads on the parallel port
// assumes the caller spaces its calls; signals move 1 ns after an edge
module csd_host_model
(
  input  wire logic        mclk_in,   // clock
  output logic      [11:0] addr_out,  // address
  output logic             wr_out,    // write strobe
  output logic      [7:0]  wdata_out, // write data
  input  wire logic [7:0]  rdata_in   // read data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {addr_out, wr_out, wdata_out} = '0;
  // one write: address, data and strobe set after an edge, strobe dropped one cycle later
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    #1 {addr_out, wr_out, wdata_out} = {a, 1'b1, d};
    @(posedge mclk_in);
    #1 wr_out = 1'b0;
  endtask
  // address held two edges so the registered data has landed
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    #1 addr_out = a;
    repeat (2) @(posedge mclk_in);
    #1 d = rdata_in;
  endtask
endmodule

// ==== verif/cc_supply_match_debounce_irq_tb.sv ====
// self-checking bench for the irq enable and debounce block
// assumes short step parameters so debounce periods run in tens of cycles
module cc_supply_match_debounce_irq_tb
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 1'b0, resetn_in = 1'b0, scan_end = 1'b0, wr, p_irq, d_irq, l1_irq;
  logic [11:0] addr;
  logic [7:0]  wdata, rdata, res, v, raw = 8'h00, pstat = 8'h00;
  logic [2:0]  dstat = 3'h0;
  logic        oc = 1'b0, oc_f;
  int          err_count = 0, num_checks = 0;
  logic [7:0]  rst_val [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0a, 8'h02,
                                8'h00, 8'h00, 8'h00};
  always #12.5 mclk_in = ~mclk_in;
  csd_host_model host (.mclk_in, .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
    .rdata_in(rdata));
  csd_irq_debounce #(.MS_CYCLES(10), .COARSE_CYCLES(10)) uut (.mclk_in, .resetn_in,
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .line1_raw_in(raw), .line2_raw_in(raw), .supply_raw_in(raw), .scan_end_in(scan_end),
    .debounce_step_select_in(1'b0), .power_status_in(pstat), .debug_status_in(dstat),
    .delivery_level_in(1'b0), .overcurrent_in(oc), .backdrive_in(2'b00),
    .line1_match_result_out(res), .line2_match_result_out(), .supply_match_result_out(),
    .line1_match_change_irq_out(l1_irq), .line2_match_change_irq_out(), .line_irq_out(),
    .supply_irq_out(), .power_irq_out(p_irq), .debug_irq_out(d_irq),
    .delivery_debounced_out(), .overcurrent_debounced_out(oc_f), .backdrive_debounced_out());
  // ---
  // helpers
  // ---
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    host.rd(a, v);
    check($sformatf("register %h", a), e, v);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog: the sequence needs well under 20 us
  initial
  begin
    #200us;
    err_count++;
    summarize();
  end
  // ---
  // main sequence
  // ---
  initial
  begin
    cyc(4);
    resetn_in = 1'b1;
    host.wr(12'h0810, 8'hff);
    for (int i = 0; i < 11; i++)
      rdchk(12'h0812 + 12'(i), rst_val[i]);
    for (int i = 0; i < 11; i++)
      host.wr(12'h0812 + 12'(i), 8'hff);
    for (int i = 0; i < 11; i++)
      rdchk(12'h0812 + 12'(i), (i == 2 || i == 10) ? 8'h3d : (i == 4) ? 8'h07 : 8'hff);
    raw = 8'h01; // include written but not yet applied
    cyc(4);
    check("line1 match", 8'h01, res);
    check("line1 irq", 8'h01, {7'h00, l1_irq});
    host.wr(12'h0806, 8'h01);
    cyc(3);
    check("line1 irq", 8'h00, {7'h00, l1_irq});
    host.wr(12'h0817, 8'h03);
    scan_end = 1'b1;
    cyc(1);
    scan_end = 1'b0;
    cyc(3);
    raw = 8'h00;
    cyc(15);
    check("line1 held", 8'h01, res);
    cyc(35);
    check("line1 settled", 8'h00, res);
    pstat = 8'h02;
    host.wr(12'h0815, 8'h01);
    cyc(3);
    check("power irq", 8'h00, {7'h00, p_irq});
    pstat = 8'h01;
    cyc(3);
    check("power irq", 8'h01, {7'h00, p_irq});
    dstat = 3'h4;
    cyc(3);
    check("debug irq", 8'h01, {7'h00, d_irq});
    host.wr(12'h0816, 8'h03);
    cyc(3);
    check("debug irq", 8'h00, {7'h00, d_irq});
    // overcurrent filter: two 10-cycle steps, phase makes it 12 to 21 cycles
    host.wr(12'h0819, 8'h02);
    oc = 1'b1;
    cyc(10);
    check("overcurrent held", 8'h00, {7'h00, oc_f});
    cyc(20);
    check("overcurrent settled", 8'h01, {7'h00, oc_f});
    summarize();
  end
endmodule
